/* mp_pin_pkg.sv */
// constants, types and register map for the multipurpose pin value block
// assumes a 16-bit control port address space and one system clock
package mp_pin_pkg;
  localparam int unsigned PIN_COUNT = 26;
  localparam int unsigned LO_COUNT = 14;
  localparam int unsigned HI_COUNT = 12;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [15:0] FORCED_LO_BASE = 16'hf520;
  localparam logic [15:0] FORCED_HI_BASE = 16'hf5d0;
  localparam logic [15:0] SAMPLED_LO_BASE = 16'hf530;
  localparam logic [15:0] SAMPLED_HI_BASE = 16'hf5e0;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam int unsigned LEVEL_BIT = 0;

  typedef enum logic [2:0] {
    MODE_GP_IN = 3'b000,
    MODE_CTRL_PORT = 3'b001,
    MODE_OUT_PULLUP = 3'b010,
    MODE_OUT_PLAIN = 3'b011,
    MODE_PDM_IN = 3'b100,
    MODE_PANIC_OUT = 3'b101,
    MODE_SPI_SEL = 3'b110
  } pin_function_select_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic rvalid;
    logic [DATA_W-1:0] rdata;
  } reg_rsp_t;

  typedef struct packed {
    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    logic [PIN_COUNT-1:0] forced_level_bit;
    logic [PIN_COUNT-1:0] sampled_level_bit;
    logic [PIN_COUNT-1:0] core_level;
    reg_rsp_t rsp;
  } mp_state_t;
endpackage

/* mp_pin_value_regs.sv */
// value registers for the multipurpose pins: forced levels and sampled levels
// assumes pin mode and enable come from the pin configuration logic, same clock
`timescale 1ns/1ns
module mp_pin_value_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // control port register access
  input wire mp_pin_pkg::reg_req_t req,
  output mp_pin_pkg::reg_rsp_t rsp,
  // pin configuration
  input wire logic [mp_pin_pkg::PIN_COUNT-1:0] multipurpose_select,
  input wire mp_pin_pkg::pin_function_select_t [mp_pin_pkg::PIN_COUNT-1:0] pin_function_select,
  // pins and core side
  input wire logic [mp_pin_pkg::PIN_COUNT-1:0] pin_in,
  output logic [mp_pin_pkg::PIN_COUNT-1:0] core_level
);
  import mp_pin_pkg::*;

  // returns {hit, index}; hi range pins follow the lo range pins
  function automatic logic [IDX_W:0] decode(input logic [15:0] a, input logic [15:0] lo,
                                            input logic [15:0] hi);
    logic [15:0] off_lo;
    logic [15:0] off_hi;
    off_lo = a - lo;
    off_hi = a - hi;
    if (a >= lo && off_lo < 16'(LO_COUNT)) begin
      return {1'b1, off_lo[IDX_W-1:0]};
    end else if (a >= hi && off_hi < 16'(HI_COUNT)) begin
      return {1'b1, IDX_W'(off_hi[IDX_W-1:0] + IDX_W'(LO_COUNT))};
    end
    return '0;
  endfunction

  // per-pin mask of enabled pins whose mode matches the given code
  function automatic logic [PIN_COUNT-1:0] mode_mask(
    input logic [PIN_COUNT-1:0] sel,
    input pin_function_select_t [PIN_COUNT-1:0] mode,
    input pin_function_select_t code
  );
    logic [PIN_COUNT-1:0] m;
    m = '0;
    for (int i = 0; i < PIN_COUNT; i++) begin
      m[i] = sel[i] && mode[i] == code;
    end
    return m;
  endfunction

  mp_state_t st_q;
  mp_state_t st_d;
  logic [IDX_W:0] wr_dec;
  logic [IDX_W:0] rd_dec;
  logic [IDX_W:0] wo_dec;
  logic [PIN_COUNT-1:0] ctrl_mask;
  logic [PIN_COUNT-1:0] gp_mask;
  logic [PIN_COUNT-1:0] in_mask;

  always_comb begin
    wr_dec = decode(req.addr, FORCED_LO_BASE, FORCED_HI_BASE);
    rd_dec = decode(req.addr, SAMPLED_LO_BASE, SAMPLED_HI_BASE);
    wo_dec = wr_dec;
    ctrl_mask = mode_mask(multipurpose_select, pin_function_select, MODE_CTRL_PORT);
    gp_mask = mode_mask(multipurpose_select, pin_function_select, MODE_GP_IN);
    // mode 001 is still an input, so its pin is logged too
    in_mask = ctrl_mask | gp_mask;
  end

  always_comb begin
    st_d = st_q;
    st_d.sync1 = pin_in;
    st_d.sync2 = st_q.sync1;
    st_d.rsp.rvalid = 1'b0;
    // store regardless of mode; only its use is gated
    if (req.wr && wr_dec[IDX_W]) begin
      st_d.forced_level_bit[wr_dec[IDX_W-1:0]] = req.wdata[LEVEL_BIT];
    end
    // disabled or non-input pins hold their last logged level
    st_d.sampled_level_bit = (st_q.sampled_level_bit & ~in_mask) | (st_q.sync2 & in_mask);
    st_d.core_level = (st_q.forced_level_bit & ctrl_mask) | (st_q.sync2 & gp_mask);
    if (req.rd) begin
      st_d.rsp.rvalid = 1'b1;
      st_d.rsp.rdata = REG_RESET;
      if (rd_dec[IDX_W]) begin
        st_d.rsp.rdata[LEVEL_BIT] = st_q.sampled_level_bit[rd_dec[IDX_W-1:0]];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rsp = st_q.rsp;
  assign core_level = st_q.core_level;

  chk_forced_to_core: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(sys_rst) |-> ((st_q.core_level ^ $past(st_q.forced_level_bit))
      & $past(ctrl_mask)) == '0)
    else $error("core level does not follow forced bit");

  chk_gp_input: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(sys_rst) |-> ((st_q.core_level ^ $past(st_q.sync2)) & $past(gp_mask)) == '0)
    else $error("core level does not follow plain input");

  chk_write_stores: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (req.wr && wr_dec[IDX_W]) |=>
      st_q.forced_level_bit[$past(wr_dec[IDX_W-1:0])] == $past(req.wdata[LEVEL_BIT]))
    else $error("forced bit not stored");

  chk_reset_clears: assert property (@(posedge clk_sys) disable iff (1'b0)
    $past(sys_rst) |-> (st_q.forced_level_bit == '0 && st_q.sampled_level_bit == '0
      && st_q.core_level == '0 && !st_q.rsp.rvalid))
    else $error("state not cleared by reset");

  chk_wo_readback: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (req.rd && wo_dec[IDX_W]) |=> (st_q.rsp.rvalid && st_q.rsp.rdata == REG_RESET))
    else $error("write-only register read back nonzero");

  chk_read_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (req.rd && rd_dec[IDX_W]) |=> (st_q.rsp.rvalid
      && st_q.rsp.rdata == {15'h0000, $past(st_q.sampled_level_bit[rd_dec[IDX_W-1:0]])}))
    else $error("sampled register read wrong");

  chk_sample_follows: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(sys_rst) |-> ((st_q.sampled_level_bit ^ $past(st_q.sync2)) & $past(in_mask)) == '0)
    else $error("sampled bit does not follow input pin");

  chk_ignore_disabled: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(sys_rst) |-> (((st_q.sampled_level_bit ^ $past(st_q.sampled_level_bit))
      & ~$past(multipurpose_select)) == '0
      && (st_q.core_level & ~$past(multipurpose_select)) == '0))
    else $error("disabled pin settings not ignored");

  chk_sync_depth: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!$past(sys_rst) && !$past(sys_rst, 2)) |-> st_q.sync2 == $past(pin_in, 2))
    else $error("synchroniser depth wrong");

  chk_pin_to_sample: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3))
      |-> ((st_q.sampled_level_bit ^ $past(pin_in, 3)) & $past(in_mask)) == '0)
    else $error("sampled bit is not the pin level three edges back");

  chk_pin_to_core: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3))
      |-> ((st_q.core_level ^ $past(pin_in, 3)) & $past(gp_mask)) == '0)
    else $error("plain input core level is not the pin three edges back");

  chk_sampled_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(sys_rst) |-> ((st_q.sampled_level_bit ^ $past(st_q.sampled_level_bit))
      & ~$past(in_mask)) == '0)
    else $error("sampled bit moved for a pin that is not an input");

  chk_non_input_core: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(sys_rst) |-> (st_q.core_level & ~$past(in_mask)) == '0)
    else $error("core level set for a pin that is not an input");

  chk_forced_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(req.wr && wr_dec[IDX_W]) |=> $stable(st_q.forced_level_bit))
    else $error("forced bits changed without a mapped write");

  chk_gap_ignored: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (req.wr && req.addr == FORCED_LO_BASE + 16'(LO_COUNT)) |=> $stable(st_q.forced_level_bit))
    else $error("write past the lower range changed a forced bit");

  chk_hi_gap_ignored: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (req.wr && req.addr == FORCED_HI_BASE + 16'(HI_COUNT)) |=> $stable(st_q.forced_level_bit))
    else $error("write past the upper range changed a forced bit");

  chk_lo_first_pin: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (req.wr && req.addr == FORCED_LO_BASE)
      |=> st_q.forced_level_bit[0] == $past(req.wdata[LEVEL_BIT]))
    else $error("first lower range write went to the wrong pin");

  chk_lo_last_pin: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (req.wr && req.addr == FORCED_LO_BASE + 16'(LO_COUNT - 1))
      |=> st_q.forced_level_bit[LO_COUNT-1] == $past(req.wdata[LEVEL_BIT]))
    else $error("last lower range write went to the wrong pin");

  chk_hi_last_pin: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (req.wr && req.addr == FORCED_HI_BASE + 16'(HI_COUNT - 1))
      |=> st_q.forced_level_bit[PIN_COUNT-1] == $past(req.wdata[LEVEL_BIT]))
    else $error("last upper range write went to the wrong pin");

  chk_lo_first_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (req.rd && req.addr == SAMPLED_LO_BASE)
      |=> st_q.rsp.rdata == {15'h0000, $past(st_q.sampled_level_bit[0])})
    else $error("first lower range read came from the wrong pin");

  chk_hi_last_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (req.rd && req.addr == SAMPLED_HI_BASE + 16'(HI_COUNT - 1))
      |=> st_q.rsp.rdata == {15'h0000, $past(st_q.sampled_level_bit[PIN_COUNT-1])})
    else $error("last upper range read came from the wrong pin");

  chk_rvalid_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q.rsp.rvalid |-> ($past(req.rd) && !$past(sys_rst)))
    else $error("read answer without a read");

  chk_read_answer: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.rd |=> st_q.rsp.rvalid)
    else $error("read not answered one cycle later");

  chk_rdata_upper: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q.rsp.rdata[DATA_W-1:1] == '0)
    else $error("reserved read data bits not zero");

  chk_rdata_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !req.rd |=> $stable(st_q.rsp.rdata))
    else $error("read data moved without a read");

  chk_sync_first: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(sys_rst) |-> st_q.sync1 == $past(pin_in))
    else $error("first synchroniser stage does not follow the pin");
endmodule

/* mp_pin_driver.sv */
// model of the external logic that drives the multipurpose pins
// assumes the bench sets the wanted levels; pins move a little after an edge
`timescale 1ns/1ns
module mp_pin_driver (
  // clock
  input wire logic clk_sys,
  // wanted and driven levels
  input wire logic [mp_pin_pkg::PIN_COUNT-1:0] want,
  output logic [mp_pin_pkg::PIN_COUNT-1:0] pin_in
);
  import mp_pin_pkg::*;
  // off the edge, so the synchroniser sees a truly late change
  always @(posedge clk_sys) pin_in <= #1 want;
endmodule

/* multipurpose_pin_value_regs_tb.sv */
// self-checking bench for the multipurpose pin value registers
// assumes the pin model in mp_pin_driver and the register port of the notes
`timescale 1ns/1ns
module multipurpose_pin_value_regs_tb;
  import mp_pin_pkg::*;
  logic clk_sys;
  logic sys_rst;
  reg_req_t req;
  reg_rsp_t rsp;
  logic [PIN_COUNT-1:0] multipurpose_select;
  logic [PIN_COUNT-1:0] want;
  logic [PIN_COUNT-1:0] pin_in;
  logic [PIN_COUNT-1:0] core_level;
  pin_function_select_t [PIN_COUNT-1:0] pin_function_select;
  int n_mismatch;
  int total_checks;
  mp_pin_value_regs i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .rsp(rsp),
    .multipurpose_select(multipurpose_select), .pin_function_select(pin_function_select),
    .pin_in(pin_in), .core_level(core_level));
  mp_pin_driver i_pins (.clk_sys(clk_sys), .want(want), .pin_in(pin_in));
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1 req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge clk_sys);
    #1 req.wr = 1'h0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    #1 req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 16'h0000};
    @(posedge clk_sys);
    #1 req.rd = 1'h0;
    chk("rvalid", {15'h0000, rsp.rvalid}, 16'h0001);
    chk("rdata", rsp.rdata, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // whole run is under a hundred cycles; wide margin before giving up
  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    sys_rst = 1'h1;
    req = '0;
    multipurpose_select = '0;
    want = '0;
    for (int i = 0; i < PIN_COUNT; i++) pin_function_select[i] = MODE_CTRL_PORT;
    settle(5);
    sys_rst = 1'h0;
    rd(16'hf530, 16'h0000);
    rd(16'hf5eb, 16'h0000);
    $display("reset test done");
    multipurpose_select = '1;
    wr(16'hf520, 16'hffff);
    wr(16'hf5db, 16'h0001);
    settle(2);
    chk("core low", core_level[15:0], 16'h0001);
    chk("core high", {6'h00, core_level[25:16]}, 16'h0200);
    rd(16'hf520, 16'h0000);
    wr(16'hf520, 16'hfffe);
    settle(2);
    chk("core pin0", {15'h0000, core_level[0]}, 16'h0000);
    wr(16'hf52d, 16'h0001);
    wr(16'hf52e, 16'h0001);
    wr(16'hf5dc, 16'h0001);
    settle(2);
    chk("core range ends", core_level[15:0], 16'h2000);
    chk("core upper end", {6'h00, core_level[25:16]}, 16'h0200);
    $display("forced level test done");
    want[3] = 1'h1;
    settle(5);
    chk("core pin3", {15'h0000, core_level[3]}, 16'h0000);
    rd(16'hf533, 16'h0001);
    want[3] = 1'h0;
    pin_function_select[3] = MODE_GP_IN;
    settle(5);
    want[3] = 1'h1;
    settle(3);
    chk("core early", {15'h0000, core_level[3]}, 16'h0000);
    settle(1);
    chk("core plain", {15'h0000, core_level[3]}, 16'h0001);
    rd(16'hf533, 16'h0001);
    multipurpose_select[3] = 1'h0;
    settle(2);
    chk("core off", {15'h0000, core_level[3]}, 16'h0000);
    $display("input test done");
    rd(16'hf533, 16'h0001);
    sys_rst = 1'h1;
    settle(2);
    sys_rst = 1'h0;
    chk("core after reset", {6'h00, core_level[25:16]}, 16'h0000);
    rd(16'hf533, 16'h0000);
    $display("mid-run reset test done");
    multipurpose_select[3] = 1'h1;
    pin_function_select[3] = MODE_OUT_PLAIN;
    settle(5);
    chk("core output mode", {15'h0000, core_level[3]}, 16'h0000);
    rd(16'hf533, 16'h0000);
    pin_function_select[3] = MODE_GP_IN;
    settle(2);
    chk("core input again", {15'h0000, core_level[3]}, 16'h0001);
    rd(16'hf533, 16'h0001);
    $display("mode test done");
    wrap_up();
  end
endmodule
